// ---- core/art_regs.sv ----
// Purpose: APB register bank for analog regulator and test controls
// Assumes: Single clock mclk, synchronous active-low reset rst_b
// Notes: Zero wait states; unmapped reads give zero with pslverr
//
// Functional notes
// - ADC regulator trim at bits 6..3, resets to 1000 nominal.
// - ADC regulator enable at bit 0, one on, resets off.
// - Front-end regulator trim at bits 6..3, same codes, reset 1000.
// - Front-end regulator enable at bit 0, one enables.
// - Synth regulator trim at bits 6..3, same trim codes.
// - Synth regulator enable at bit 0, one enables.
// - Test word: bit 23 load mode, bit 22 load enable.
// - Bits 16..15 route test pad: quiescent, pad, GPIO, unused.
// - Bit 14 drives voltage observation mode output.
// - Bit 13 drives current observation mode output.
// - Bit 12 drives clock observation mode output.
// - Bit 11 drives flag observation mode output.
// - Bits 10..7 pick the observed internal voltage.
// - Bit 6 picks the observed internal current.
// - Bits 5..3 pick the observed internal clock.
// - Bits 2..1 pick the observed internal flag.
// - Bit 0 bypasses the voltage observation buffer.
// - Converter trim read-write; software syncs to always-on after.
// - Converter current limit read-write; sync needed before effect.
// - Converter enable and bypass read-write, forwarded to always-on.
//
// Register access over APB was decided locally.
`include "art_defs.svh"
`default_nettype none
module art_regs (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Analog controls
    output art_pkg::art_ldo_t rx_adc_ldo,
    output art_pkg::art_ldo_t frontend_ldo,
    output art_pkg::art_ldo_t synth_ldo,
    output art_pkg::art_observe_t observe,
    output art_pkg::art_conv_t converter
);
    import art_pkg::*;

    logic [31:0] conv_reg;
    logic [31:0] rx_adc_reg;
    logic [31:0] frontend_reg;
    logic [31:0] synth_reg;
    logic [31:0] test_reg;
    logic setup;
    logic wr_en;
    logic hit;
    logic [31:0] rd_next;

    // Byte-lane merge keeping only implemented bits
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] wd,
                                          input logic [3:0] strb,
                                          input logic [31:0] mask);
        logic [31:0] lanes;
        lanes = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
        merge = ((old & ~lanes) | (wd & lanes)) & mask;
    endfunction : merge

    // Decode in setup; a write lands at the edge that samples pready high
    assign setup = psel & ~penable;
    assign wr_en = psel & penable & pready & pwrite;
    always_comb begin
        hit = 1'b1;
        rd_next = 32'h0000_0000;
        unique case (paddr)
            `ART_OFF_CONV: rd_next = conv_reg;
            `ART_OFF_RXADC: rd_next = rx_adc_reg;
            `ART_OFF_FRONTEND: rd_next = frontend_reg;
            `ART_OFF_SYNTH: rd_next = synth_reg;
            `ART_OFF_TEST: rd_next = test_reg;
            default: hit = 1'b0;
        endcase
    end

    // Converter word, values forwarded to always-on domain
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            conv_reg <= `ART_CONV_RST;
        end else if (wr_en && paddr == `ART_OFF_CONV) begin
            conv_reg <= merge(conv_reg, pwdata, pstrb,
                              `ART_CONV_MASK);
        end
    end

    // Receive ADC regulator word
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            rx_adc_reg <= `ART_REG_RST;
        end else if (wr_en && paddr == `ART_OFF_RXADC) begin
            rx_adc_reg <= merge(rx_adc_reg, pwdata, pstrb,
                                `ART_REG_MASK);
        end
    end

    // Front-end regulator word
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            frontend_reg <= `ART_REG_RST;
        end else if (wr_en && paddr == `ART_OFF_FRONTEND) begin
            frontend_reg <= merge(frontend_reg, pwdata, pstrb,
                                  `ART_REG_MASK);
        end
    end

    // Synthesizer regulator word
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            synth_reg <= `ART_REG_RST;
        end else if (wr_en && paddr == `ART_OFF_SYNTH) begin
            synth_reg <= merge(synth_reg, pwdata, pstrb,
                               `ART_REG_MASK);
        end
    end

    // Test observation word
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            test_reg <= `ART_TEST_RST;
        end else if (wr_en && paddr == `ART_OFF_TEST) begin
            test_reg <= merge(test_reg, pwdata, pstrb,
                              `ART_TEST_MASK);
        end
    end

    // APB answer registered in the setup cycle, ready in access
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= setup;
            pslverr <= setup & ~hit;
            prdata <= (setup && !pwrite) ? rd_next : 32'h0000_0000;
        end
    end

    // Regulator outputs taken straight from the register flops
    assign rx_adc_ldo = {rx_adc_reg[`ART_TRIM_HI:`ART_TRIM_LO],
                         rx_adc_reg[`ART_ON_BIT]};
    assign frontend_ldo = {frontend_reg[`ART_TRIM_HI:`ART_TRIM_LO],
                           frontend_reg[`ART_ON_BIT]};
    assign synth_ldo = {synth_reg[`ART_TRIM_HI:`ART_TRIM_LO],
                        synth_reg[`ART_ON_BIT]};

    // Observation outputs: load bits, pad route, modes, picks, bypass
    assign observe = {test_reg[`ART_LOAD_TRIM_HI:`ART_LOAD_TRIM_LO],
                      test_reg[`ART_LOAD_MODE_BIT],
                      test_reg[`ART_LOAD_ON_BIT],
                      test_reg[`ART_PAD_HI:`ART_PAD_LO],
                      test_reg[`ART_VOLT_ON_BIT],
                      test_reg[`ART_CURR_ON_BIT],
                      test_reg[`ART_CLK_ON_BIT],
                      test_reg[`ART_FLAG_ON_BIT],
                      test_reg[`ART_VPICK_HI:`ART_VPICK_LO],
                      test_reg[`ART_IPICK_BIT],
                      test_reg[`ART_CPICK_HI:`ART_CPICK_LO],
                      test_reg[`ART_FPICK_HI:`ART_FPICK_LO],
                      test_reg[`ART_SKIP_BIT]};

    // Converter outputs to the always-on domain
    assign converter = {conv_reg[`ART_CLIM_HI:`ART_CLIM_LO],
                        conv_reg[`ART_COUT_HI:`ART_COUT_LO],
                        conv_reg[`ART_CBP_BIT],
                        conv_reg[`ART_CON_BIT]};
endmodule : art_regs
`default_nettype wire

// ---- core/art_defs.svh ----
// Purpose: Offsets, field positions and reset values of the analog regs
// Assumes: Byte addresses on a 32-bit APB bus
// Notes: Converter word offset is a local choice
`ifndef ART_DEFS_SVH
`define ART_DEFS_SVH

`define ART_OFF_CONV 8'h38
`define ART_OFF_RXADC 8'h3c
`define ART_OFF_FRONTEND 8'h40
`define ART_OFF_SYNTH 8'h44
`define ART_OFF_TEST 8'h48

`define ART_REG_RST 32'h0000_0040
`define ART_TEST_RST 32'h0f00_0000
`define ART_CONV_RST 32'h0000_0000

`define ART_REG_MASK 32'h0000_0079
`define ART_TEST_MASK 32'hffc1_ffff
`define ART_CONV_MASK 32'h0000_03ff

`define ART_TRIM_HI 6
`define ART_TRIM_LO 3
`define ART_ON_BIT 0

`define ART_LOAD_TRIM_HI 31
`define ART_LOAD_TRIM_LO 24
`define ART_LOAD_MODE_BIT 23
`define ART_LOAD_ON_BIT 22
`define ART_PAD_HI 16
`define ART_PAD_LO 15
`define ART_VOLT_ON_BIT 14
`define ART_CURR_ON_BIT 13
`define ART_CLK_ON_BIT 12
`define ART_FLAG_ON_BIT 11
`define ART_VPICK_HI 10
`define ART_VPICK_LO 7
`define ART_IPICK_BIT 6
`define ART_CPICK_HI 5
`define ART_CPICK_LO 3
`define ART_FPICK_HI 2
`define ART_FPICK_LO 1
`define ART_SKIP_BIT 0

// Converter word: limit [9:8], trim [7:2], bypass [1], on [0]
`define ART_CLIM_HI 9
`define ART_CLIM_LO 8
`define ART_COUT_HI 7
`define ART_COUT_LO 2
`define ART_CBP_BIT 1
`define ART_CON_BIT 0

`endif

// ---- core/art_pkg.sv ----
// Purpose: Types shared by the analog regulator and test register bank
// Assumes: Constants live in art_defs.svh
// Notes: Structs group outputs that travel together
`default_nettype none
package art_pkg;
    typedef enum logic [1:0] {
        ART_PAD_QUIESCENT,
        ART_PAD_TEST,
        ART_PAD_GPIO,
        ART_PAD_UNUSED
    } art_pad_t;

    typedef struct packed {
        logic [3:0] trim;
        logic on;
    } art_ldo_t;

    typedef struct packed {
        logic [7:0] load_trim;
        logic load_const_curr;
        logic load_on;
        art_pad_t pad_route;
        logic volt_on;
        logic curr_on;
        logic clk_on;
        logic flag_on;
        logic [3:0] volt_pick;
        logic curr_pick;
        logic [2:0] clk_pick;
        logic [1:0] flag_pick;
        logic buffer_skip;
    } art_observe_t;

    typedef struct packed {
        logic [1:0] current_limit;
        logic [5:0] out_trim;
        logic bypass;
        logic on;
    } art_conv_t;
endpackage : art_pkg
`default_nettype wire

// ---- test/art_regs_asserts.sv ----
// Purpose: Concurrent checks on the analog control register bank
// Assumes: Zero-wait APB, write lands at the access edge
// Notes: Full-word writes only are checked against the outputs
`default_nettype none
module art_regs_asserts (
    // Clock, reset and APB
    input wire logic mclk, rst_b, psel, penable, pwrite, pready, pslverr,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata, prdata,
    input wire logic [3:0] pstrb,
    // Analog controls
    input wire art_pkg::art_ldo_t rx_adc_ldo, frontend_ldo, synth_ldo,
    input wire art_pkg::art_observe_t observe,
    input wire art_pkg::art_conv_t converter
);
    import art_pkg::*;
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_b);
    logic [31:0] wd1, wd2;
    logic wr;
    // Full-word write in its setup cycle
    assign wr = psel && !penable && pwrite && pstrb == 4'hf;
    // Write data two edges back, lined up with the outputs
    always_ff @(posedge mclk) begin
        wd1 <= pwdata;
        wd2 <= wd1;
    end
    property p_rx;
        logic [31:0] d;
        (wr && paddr == 8'h3c, d = pwdata) |-> ##2 rx_adc_ldo == {d[6:3], d[0]};
    endproperty
    a_rx: assert property (p_rx) else $error("adc reg out");
    property p_fe;
        logic [31:0] d;
        (wr && paddr == 8'h40, d = pwdata) |-> ##2 frontend_ldo == {d[6:3], d[0]};
    endproperty
    a_fe: assert property (p_fe) else $error("fe reg out");
    property p_sy;
        wr && paddr == 8'h44 |-> ##2 synth_ldo == {wd2[6:3], wd2[0]};
    endproperty
    a_sy: assert property (p_sy) else $error("synth out");
    property p_load;
        wr && paddr == 8'h48 |-> ##2
            {observe.load_const_curr, observe.load_on} == wd2[23:22];
    endproperty
    a_load: assert property (p_load) else $error("load bits");
    property p_pad;
        wr && paddr == 8'h48 |-> ##2 observe.pad_route == wd2[16:15];
    endproperty
    a_pad: assert property (p_pad) else $error("pad route");
    property p_mode;
        wr && paddr == 8'h48 |-> ##1 1'b1 ##1 {observe.volt_on,
            observe.curr_on, observe.clk_on, observe.flag_on} == wd2[14:11];
    endproperty
    a_mode: assert property (p_mode) else $error("modes");
    property p_pick;
        wr && paddr == 8'h48 |-> ##2 observe[10:0] == wd2[10:0];
    endproperty
    a_pick: assert property (p_pick) else $error("picks");
    property p_conv;
        wr && paddr == 8'h38 |-> ##2 converter == wd2[9:0];
    endproperty
    a_conv: assert property (p_conv) else $error("conv");
    property p_rsv;
        pready && !pwrite && paddr inside {8'h3c, 8'h40, 8'h44}
            |-> prdata[31:7] == 25'h0 && prdata[2:1] == 2'h0;
    endproperty
    a_rsv: assert property (p_rsv) else $error("rsv bits");
    property p_err;
        psel && !penable && !(paddr inside {8'h38, 8'h3c, 8'h40, 8'h44,
            8'h48}) |=> pready && pslverr && prdata == 32'h0;
    endproperty
    a_err: assert property (p_err) else $error("unmapped");
    property p_rst;
        $rose(rst_b) |-> rx_adc_ldo == 5'h10 && synth_ldo == 5'h10
            && observe.load_trim == 8'h0f && converter == 10'h0;
    endproperty
    a_rst: assert property (p_rst) else $error("reset out");
endmodule : art_regs_asserts
bind art_regs art_regs_asserts u_chk (.mclk(mclk), .rst_b(rst_b),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pready(pready),
    .pslverr(pslverr), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pstrb(pstrb), .rx_adc_ldo(rx_adc_ldo), .frontend_ldo(frontend_ldo),
    .synth_ldo(synth_ldo), .observe(observe), .converter(converter));
`default_nettype wire

// ---- test/tb_top.sv ----
// Purpose: Self-checking bench for the analog control register bank
// Assumes: APB driven at rising edges, slave answers on its own
// Notes: Outputs are sampled just after the edge that ends a write
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    import art_pkg::*;
    logic mclk, rst_b, psel, penable, pwrite, pready, pslverr, err;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0] pstrb;
    art_ldo_t lo [3];
    art_observe_t obs;
    art_conv_t conv;
    int bad_count = 0;
    int n_compared = 0;
    art_regs uut (.mclk(mclk), .rst_b(rst_b), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .rx_adc_ldo(lo[0]), .frontend_ldo(lo[1]), .synth_ldo(lo[2]),
        .observe(obs), .converter(conv));
    // 125 MHz clock
    initial begin
        mclk = 0;
        forever #4 mclk = ~mclk;
    end
    task automatic chk(input logic [31:0] got, exp);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("FAIL %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    // One APB transfer; waits for pready, then releases
    task automatic apb(input logic [7:0] a, input logic w,
                       input logic [31:0] d, input logic [3:0] s);
        int n;
        n = 0;
        @(posedge mclk);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge mclk);
        penable <= 1;
        do begin
            @(posedge mclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            bad_count++;
            $display("FAIL %0t no pready", $time);
        end
        rd = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
        #1;
    endtask : apb
    // Regulator words: reset, full write, masked lanes, clear
    task automatic t_ldo;
        logic [7:0] a [3] = '{8'h3c, 8'h40, 8'h44};
        foreach (a[i]) begin
            chk({27'h0, lo[i]}, 32'h10);
            apb(a[i], 0, 0, 4'hf);
            chk(rd, 32'h40);
            apb(a[i], 1, 32'hffff_ffff, 4'hf);
            chk({27'h0, lo[i]}, 32'h1f);
            apb(a[i], 0, 0, 4'hf);
            chk(rd, 32'h79);
            apb(a[i], 1, 32'h41, 4'h0);
            apb(a[i], 0, 0, 4'hf);
            chk(rd, 32'h79);
            apb(a[i], 1, 32'hffff_ff86, 4'h1);
            chk({27'h0, lo[i]}, 32'h0);
        end
    endtask : t_ldo
    // Test word: every pad code, every field, then one lane only
    task automatic t_test;
        logic [31:0] d [5] = '{32'h0, 32'h5555_5555, 32'haaaa_aaaa,
                               32'h0001_8000, 32'hffff_ffff};
        foreach (d[i]) begin
            apb(8'h48, 1, d[i], 4'hf);
            chk({3'h0, obs}, {3'h0, d[i][31:22], d[i][16:0]});
            apb(8'h48, 0, 0, 4'hf);
            chk(rd, d[i] & 32'hffc1_ffff);
        end
        apb(8'h48, 1, 32'h0, 4'h4);
        chk({3'h0, obs}, 32'h07f8_ffff);
    endtask : t_test
    // Converter word and an unmapped place
    task automatic t_conv;
        apb(8'h38, 1, 32'hffff_ffff, 4'hf);
        chk({22'h0, conv}, 32'h3ff);
        apb(8'h38, 1, 32'h155, 4'hf);
        chk({22'h0, conv}, 32'h155);
        apb(8'h4c, 1, 32'hffff_ffff, 4'hf);
        apb(8'h4c, 0, 0, 4'hf);
        chk(rd, 32'h0);
        chk({31'h0, err}, 32'h1);
    endtask : t_conv
    task automatic stop_test;
        $display("mismatches %0d compares %0d", bad_count, n_compared);
        if (bad_count == 0 && n_compared > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : stop_test
    initial begin
        rst_b = 0;
        psel = 0;
        penable = 0;
        pwrite = 0;
        paddr = 0;
        pwdata = 0;
        pstrb = 0;
        repeat (16) @(posedge mclk);
        rst_b <= 1;
        @(posedge mclk);
        #1;
        t_ldo();
        t_test();
        t_conv();
        stop_test();
    end
    // Watchdog far beyond the roughly 120 cycles needed
    initial begin
        repeat (5000) @(posedge mclk);
        bad_count++;
        stop_test();
    end
endmodule : tb_top
`default_nettype wire
